// ==== design/msc_stats.sv ====
// Purpose: Statistics counter bank of a 10/100 Ethernet MAC with a processor register port.
// Assumes: Transmit and receive engines give one end-of-frame strobe per frame with its outcome.
// Notes:   Reads return the value one cycle later and clear the counter.
`timescale 1ns/1ps
module msc_stats (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         reset_n_i,
    // Processor register port
    input  wire msc_pkg::msc_reg_req_t        reg_req_i,
    output logic [msc_pkg::DATA_W-1:0]        reg_rdata_o,
    output logic                              reg_rvalid_o,
    // MAC configuration bits
    input  wire logic                         rx_enable_i,
    input  wire logic                         long_frame_i,
    input  wire logic                         full_duplex_i,
    // Transmit engine events
    input  wire logic                         tx_done_i,
    input  wire msc_pkg::msc_tx_outcome_t     tx_i,
    // Receive engine events
    input  wire logic                         rx_done_i,
    input  wire msc_pkg::msc_rx_outcome_t     rx_i
);

    ////////////////////////////////////////////////////////////////////////////
    // Widths and address decode

    function automatic int cnt_width(input int slot);
        case (slot)
            msc_pkg::CNT_MULTI:  cnt_width = msc_pkg::MULTI_W;
            msc_pkg::CNT_RXGOOD: cnt_width = msc_pkg::RXGOOD_W;
            msc_pkg::CNT_DEFER:  cnt_width = msc_pkg::DEFER_W;
            default:             cnt_width = msc_pkg::SMALL_W;
        endcase
    endfunction : cnt_width

    // One-hot select of the counter at an address; all zero when unmapped.
    function automatic logic [msc_pkg::NUM_CNT-1:0] cnt_select(input logic [msc_pkg::ADDR_W-1:0] addr);
        logic [msc_pkg::NUM_CNT-1:0] sel;
        sel = '0;
        for (int i = 0; i < msc_pkg::NUM_CNT; i++) begin
            if (addr == msc_pkg::MULTI_COLLISION_COUNT_OFS + msc_pkg::ADDR_W'(i * 4)) begin
                sel[i] = 1'b1;
            end
        end
        cnt_select = sel;
    endfunction : cnt_select

    ////////////////////////////////////////////////////////////////////////////
    // Event sorting and counters

    logic [msc_pkg::NUM_CNT-1:0] inc;
    logic [msc_pkg::NUM_CNT-1:0] sel;
    logic [msc_pkg::DATA_W-1:0]  cnt [msc_pkg::NUM_CNT];

    assign sel = cnt_select(reg_req_i.addr);

    msc_event_sort u_sort (
        .tx_done_i     (tx_done_i),
        .tx_i          (tx_i),
        .rx_done_i     (rx_done_i),
        .rx_i          (rx_i),
        .rx_enable_i   (rx_enable_i),
        .long_frame_i  (long_frame_i),
        .full_duplex_i (full_duplex_i),
        .inc_o         (inc)
    );

    for (genvar g = 0; g < msc_pkg::NUM_CNT; g++) begin : g_cnt
        localparam int W = cnt_width(g);
        logic [W-1:0] value;

        // Upper bits of a write are dropped; software keeps them at zero.
        msc_sat_counter #(
            .WIDTH (W)
        ) u_cnt (
            .clk_i      (clk_i),
            .reset_n_i  (reset_n_i),
            .inc_i      (inc[g]),
            .clr_i      (reg_req_i.rd && sel[g]),
            .load_i     (reg_req_i.wr && sel[g]),
            .load_val_i (reg_req_i.wdata[W-1:0]),
            .count_o    (value)
        );

        if (W < msc_pkg::DATA_W) begin : g_pad
            assign cnt[g] = {{(msc_pkg::DATA_W-W){1'b0}}, value};
        end else begin : g_full
            assign cnt[g] = value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    typedef struct packed {
        logic [msc_pkg::DATA_W-1:0] rdata;
        logic                       rvalid;
    } msc_rd_state_t;

    msc_rd_state_t state;
    msc_rd_state_t next_state;

    always_comb begin
        next_state        = state;
        next_state.rvalid = reg_req_i.rd;
        if (reg_req_i.rd) begin
            // Unmapped addresses read as zero and have no side effect.
            next_state.rdata = msc_pkg::CNT_RESET;
            for (int i = 0; i < msc_pkg::NUM_CNT; i++) begin
                if (sel[i]) begin
                    next_state.rdata = cnt[i];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state.rdata  <= msc_pkg::CNT_RESET;
            state.rvalid <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata_o  = state.rdata;
    assign reg_rvalid_o = state.rvalid;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    localparam logic [7:0]  SMALL_MAX = 8'hFF;
    localparam logic [15:0] MULTI_MAX = 16'hFFFF;

    a_underrun_alone: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        tx_done_i && tx_i.underrun && !rx_done_i |-> inc == (msc_pkg::NUM_CNT'(1) << msc_pkg::CNT_UNDER))
        else $error("underrun frame bumped another counter");

    a_read_clears: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        reg_req_i.rd && !reg_req_i.wr && sel[msc_pkg::CNT_LATE] && !inc[msc_pkg::CNT_LATE]
        |=> cnt[msc_pkg::CNT_LATE] == '0 && reg_rdata_o == $past(cnt[msc_pkg::CNT_LATE]) && reg_rvalid_o)
        else $error("read did not return and clear the counter");

    a_read_keeps_inc: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        reg_req_i.rd && !reg_req_i.wr && sel[msc_pkg::CNT_UNDER] && inc[msc_pkg::CNT_UNDER]
        |=> cnt[msc_pkg::CNT_UNDER] == 32'h0000_0001)
        else $error("increment lost on clearing read");

    a_saturate_small: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        cnt[msc_pkg::CNT_CRC][7:0] == SMALL_MAX && !reg_req_i.rd && !reg_req_i.wr
        |=> cnt[msc_pkg::CNT_CRC][7:0] == SMALL_MAX)
        else $error("8-bit counter wrapped");

    a_saturate_multi: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        cnt[msc_pkg::CNT_MULTI][15:0] == MULTI_MAX && !reg_req_i.rd && !reg_req_i.wr
        |=> cnt[msc_pkg::CNT_MULTI][15:0] == MULTI_MAX)
        else $error("16-bit counter wrapped");

    a_step_one: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        inc[msc_pkg::CNT_RXGOOD] && !sel[msc_pkg::CNT_RXGOOD] && cnt[msc_pkg::CNT_RXGOOD] != 32'h00FF_FFFF
        |=> cnt[msc_pkg::CNT_RXGOOD] == $past(cnt[msc_pkg::CNT_RXGOOD]) + 32'h0000_0001)
        else $error("good frame counter did not step by one");

    a_rx_gated: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !rx_enable_i |-> !inc[msc_pkg::CNT_RXGOOD] && !inc[msc_pkg::CNT_CRC] && !inc[msc_pkg::CNT_ALIGN])
        else $error("receive counter moved with receiver disabled");

    a_carrier_half: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        full_duplex_i |-> !inc[msc_pkg::CNT_CARR])
        else $error("carrier error counted in full duplex");

    a_defer_clean: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        inc[msc_pkg::CNT_DEFER] |-> tx_i.collisions == '0 && !tx_i.underrun && !tx_i.late_collision)
        else $error("deferral counted with collision or underrun");

    a_late_double: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        tx_done_i && !tx_i.underrun && tx_i.late_collision
        && tx_i.collisions >= msc_pkg::MULTI_COLL_MIN && tx_i.collisions <= msc_pkg::MULTI_COLL_MAX
        |-> inc[msc_pkg::CNT_LATE] && inc[msc_pkg::CNT_MULTI])
        else $error("late collision not counted twice");

    a_multi_range: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        inc[msc_pkg::CNT_MULTI] |-> tx_i.collisions >= msc_pkg::MULTI_COLL_MIN
                                    && tx_i.collisions <= msc_pkg::MULTI_COLL_MAX)
        else $error("multiple collision count outside two to fifteen");

endmodule : msc_stats

// ==== design/msc_pkg.sv ====
// Purpose: Shared constants and carrier types of the MAC statistics counter bank.
// Assumes: One clock domain; offsets are byte addresses on the processor register port.
// Notes:   Counter order here fixes the bit order of the increment vector.
package msc_pkg;

    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int NUM_CNT   = 9;
    localparam int COLL_W    = 5;
    localparam int LEN_W     = 12;

    // Counter slots, also the bit index in the increment vector.
    localparam int CNT_MULTI  = 0;
    localparam int CNT_RXGOOD = 1;
    localparam int CNT_CRC    = 2;
    localparam int CNT_ALIGN  = 3;
    localparam int CNT_DEFER  = 4;
    localparam int CNT_LATE   = 5;
    localparam int CNT_EXCESS = 6;
    localparam int CNT_UNDER  = 7;
    localparam int CNT_CARR   = 8;

    // Byte offsets of the counter registers.
    localparam logic [ADDR_W-1:0] MULTI_COLLISION_COUNT_OFS  = 8'h48;
    localparam logic [ADDR_W-1:0] RX_GOOD_FRAME_COUNT_OFS    = 8'h4C;
    localparam logic [ADDR_W-1:0] RX_CRC_ERROR_COUNT_OFS     = 8'h50;
    localparam logic [ADDR_W-1:0] RX_ALIGN_ERROR_COUNT_OFS   = 8'h54;
    localparam logic [ADDR_W-1:0] TX_DEFERRED_COUNT_OFS      = 8'h58;
    localparam logic [ADDR_W-1:0] LATE_COLLISION_COUNT_OFS   = 8'h5C;
    localparam logic [ADDR_W-1:0] EXCESS_COLLISION_COUNT_OFS = 8'h60;
    localparam logic [ADDR_W-1:0] TX_UNDERRUN_COUNT_OFS      = 8'h64;
    localparam logic [ADDR_W-1:0] CARRIER_LOSS_COUNT_OFS     = 8'h68;
    localparam logic [ADDR_W-1:0] CNT_STRIDE                 = 8'h04;

    // Counter widths, in slot order.
    localparam int MULTI_W  = 16;
    localparam int RXGOOD_W = 24;
    localparam int SMALL_W  = 8;
    localparam int DEFER_W  = 16;

    localparam logic [DATA_W-1:0] CNT_RESET = 32'h0000_0000;

    // Frame limits in bytes and collision limits.
    localparam logic [LEN_W-1:0]  MIN_FRAME_LEN   = 12'h040;
    localparam logic [LEN_W-1:0]  MAX_FRAME_LEN   = 12'h5EE;
    localparam logic [LEN_W-1:0]  MAX_LONG_LEN    = 12'h7D0;
    localparam logic [COLL_W-1:0] MULTI_COLL_MIN  = 5'h02;
    localparam logic [COLL_W-1:0] MULTI_COLL_MAX  = 5'h0F;
    localparam logic [COLL_W-1:0] EXCESS_COLL_NUM = 5'h10;

    // Outcome of one transmitted frame, valid with the end-of-frame strobe.
    typedef struct packed {
        logic [COLL_W-1:0] collisions;
        logic              late_collision;
        logic              underrun;
        logic              deferred_first;
        logic              carrier_error;
    } msc_tx_outcome_t;

    // Outcome of one received frame, valid with the end-of-frame strobe.
    typedef struct packed {
        logic [LEN_W-1:0] length;
        logic             odd_bits;
        logic             crc_error;
        logic             symbol_error;
    } msc_rx_outcome_t;

    // One processor register port access.
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } msc_reg_req_t;

endpackage : msc_pkg

// ==== design/msc_sat_counter.sv ====
// Purpose: One saturating statistics counter with clear-on-read and host load.
// Assumes: Increment, clear and load are one-cycle strobes from the parent.
// Notes:   An increment in the clearing cycle survives as a count of one.
`timescale 1ns/1ps
module msc_sat_counter #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // Control
    input  wire logic             inc_i,
    input  wire logic             clr_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] load_val_i,
    // Value
    output logic      [WIDTH-1:0] count_o
);

    if (WIDTH < 1 || WIDTH > msc_pkg::DATA_W) begin : g_bad_width
        $error("msc_sat_counter: WIDTH out of range");
    end

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } msc_cnt_state_t;

    msc_cnt_state_t state;
    msc_cnt_state_t next_state;

    localparam logic [WIDTH-1:0] CNT_MAX  = {WIDTH{1'b1}};
    localparam logic [WIDTH-1:0] CNT_ZERO = msc_pkg::CNT_RESET[WIDTH-1:0];
    localparam logic [WIDTH-1:0] CNT_ONE  = {{(WIDTH-1){1'b0}}, 1'b1};

    always_comb begin
        next_state = state;
        if (load_i) begin
            next_state.count = load_val_i;
        end else if (clr_i) begin
            next_state.count = inc_i ? CNT_ONE : CNT_ZERO;
        end else if (inc_i && state.count != CNT_MAX) begin
            next_state.count = state.count + CNT_ONE;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state.count <= CNT_ZERO;
        end else begin
            state <= next_state;
        end
    end

    assign count_o = state.count;

endmodule : msc_sat_counter

// ==== design/msc_event_sort.sv ====
// Purpose: Sorts end-of-frame outcomes into one increment strobe per counter.
// Assumes: Outcome fields are stable in the cycle of their end-of-frame strobe.
// Notes:   Purely combinational; the parent registers nothing on its path.
`timescale 1ns/1ps
module msc_event_sort (
    // Transmit side
    input  wire logic                          tx_done_i,
    input  wire msc_pkg::msc_tx_outcome_t      tx_i,
    // Receive side
    input  wire logic                          rx_done_i,
    input  wire msc_pkg::msc_rx_outcome_t      rx_i,
    // Configuration
    input  wire logic                          rx_enable_i,
    input  wire logic                          long_frame_i,
    input  wire logic                          full_duplex_i,
    // Strobes
    output logic [msc_pkg::NUM_CNT-1:0]        inc_o
);

    logic tx_ok;
    logic no_coll;
    logic excess;
    logic in_window;
    logic rx_take;

    // A frame with 16 collisions is abandoned, so it never reaches the success counters.
    assign excess  = (tx_i.collisions == msc_pkg::EXCESS_COLL_NUM);
    assign tx_ok   = tx_done_i && !tx_i.underrun;
    assign no_coll = (tx_i.collisions == '0) && !tx_i.late_collision;

    assign in_window = (rx_i.length >= msc_pkg::MIN_FRAME_LEN) &&
                       (rx_i.length <= (long_frame_i ? msc_pkg::MAX_LONG_LEN : msc_pkg::MAX_FRAME_LEN));
    assign rx_take   = rx_done_i && rx_enable_i && in_window;

    always_comb begin
        inc_o = '0;
        // A late collision also sits in the collision count, so it can land here too.
        inc_o[msc_pkg::CNT_MULTI]  = tx_ok && !excess &&
                                     tx_i.collisions >= msc_pkg::MULTI_COLL_MIN &&
                                     tx_i.collisions <= msc_pkg::MULTI_COLL_MAX;
        inc_o[msc_pkg::CNT_DEFER]  = tx_ok && tx_i.deferred_first && no_coll;
        inc_o[msc_pkg::CNT_LATE]   = tx_ok && tx_i.late_collision;
        inc_o[msc_pkg::CNT_EXCESS] = tx_ok && excess;
        inc_o[msc_pkg::CNT_UNDER]  = tx_done_i && tx_i.underrun;
        // Carrier errors only add here; nothing else above looks at them.
        inc_o[msc_pkg::CNT_CARR]   = tx_ok && tx_i.carrier_error && no_coll && !full_duplex_i;
        inc_o[msc_pkg::CNT_RXGOOD] = rx_take && !rx_i.crc_error && !rx_i.odd_bits && !rx_i.symbol_error;
        inc_o[msc_pkg::CNT_CRC]    = rx_take && !rx_i.odd_bits && rx_i.crc_error;
        inc_o[msc_pkg::CNT_ALIGN]  = rx_take && rx_i.odd_bits && rx_i.crc_error;
    end

endmodule : msc_event_sort

// ==== dv/msc_mac_engine_model.sv ====
// Purpose: Model of the MAC transmit and receive engines that feed the counter bank.
// Assumes: One frame request at a time; dly_i cycles pass before the end-of-frame strobe.
// Notes:   Outside the strobe the outcome lines show the inverse of the last outcome.
`timescale 1ns/1ps
module msc_mac_engine_model (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     reset_n_i,
    // Requests from the bench
    input  wire logic                     start_i,
    input  wire logic [1:0]               sel_i,
    input  wire logic [3:0]               dly_i,
    input  wire msc_pkg::msc_tx_outcome_t tx_val_i,
    input  wire msc_pkg::msc_rx_outcome_t rx_val_i,
    // Toward the bench (busy) and the counter bank
    output logic                          busy_o,
    output logic                          tx_done_o,
    output msc_pkg::msc_tx_outcome_t      tx_o,
    output logic                          rx_done_o,
    output msc_pkg::msc_rx_outcome_t      rx_o
);
    logic [3:0]               cnt;
    logic [1:0]               sel_q;
    logic                     fire;
    msc_pkg::msc_tx_outcome_t tx_q;
    msc_pkg::msc_rx_outcome_t rx_q;

    ////////////////////////////////////////
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_o <= 1'b0;
            cnt    <= 4'h0;
            sel_q  <= 2'h0;
            tx_q   <= '0;
            rx_q   <= '0;
        end else if (start_i && !busy_o) begin
            busy_o <= 1'b1;
            cnt    <= dly_i;
            sel_q  <= sel_i;
            tx_q   <= tx_val_i;
            rx_q   <= rx_val_i;
        end else if (fire) begin
            busy_o <= 1'b0;
        end else if (busy_o) begin
            cnt <= cnt - 4'h1;
        end
    end

    // Stale outcomes are inverted so a bank that samples off the strobe sees wrong data.
    assign fire      = busy_o && (cnt == 4'h0);
    assign tx_done_o = fire && sel_q[0];
    assign rx_done_o = fire && sel_q[1];
    assign tx_o      = tx_done_o ? tx_q : ~tx_q;
    assign rx_o      = rx_done_o ? rx_q : ~rx_q;
endmodule : msc_mac_engine_model

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench of the MAC statistics counter bank.
// Assumes: Register reads answer one cycle later; the engine model sends one frame at a time.
// Notes:   Each table row is followed by a read of all nine counters, which also clears them.
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [1:0]               sel;
        msc_pkg::msc_tx_outcome_t tx;
        msc_pkg::msc_rx_outcome_t rx;
        logic [2:0]               cfg;
        logic [8:0]               exp;
    } msc_tb_row_t;

    logic                     clk_i;
    logic                     reset_n_i;
    msc_pkg::msc_reg_req_t    req;
    logic [31:0]              rdata;
    logic                     rvalid;
    logic [2:0]               cfg;
    logic                     start;
    logic [1:0]               sel;
    logic [3:0]               dly;
    logic                     busy;
    logic                     tx_done;
    logic                     rx_done;
    msc_pkg::msc_tx_outcome_t txv;
    msc_pkg::msc_tx_outcome_t tx;
    msc_pkg::msc_rx_outcome_t rxv;
    msc_pkg::msc_rx_outcome_t rx;
    int                       fail_count;
    int                       compares;
    int                       cycles;

    // Columns: engine select, tx outcome, rx outcome, {rx enable, long, full duplex}, counters hit.
    msc_tb_row_t rows [28] = '{
        {2'h1, 9'h020, 15'h0000, 3'h4, 9'h001},
        {2'h1, 9'h0F0, 15'h0000, 3'h4, 9'h001},
        {2'h1, 9'h010, 15'h0000, 3'h4, 9'h000},
        {2'h1, 9'h100, 15'h0000, 3'h4, 9'h040},
        {2'h1, 9'h038, 15'h0000, 3'h4, 9'h021},
        {2'h1, 9'h018, 15'h0000, 3'h4, 9'h020},
        {2'h1, 9'h002, 15'h0000, 3'h4, 9'h010},
        {2'h1, 9'h022, 15'h0000, 3'h4, 9'h001},
        {2'h1, 9'h03F, 15'h0000, 3'h4, 9'h080},
        {2'h1, 9'h004, 15'h0000, 3'h4, 9'h080},
        {2'h1, 9'h001, 15'h0000, 3'h4, 9'h100},
        {2'h1, 9'h001, 15'h0000, 3'h5, 9'h000},
        {2'h1, 9'h003, 15'h0000, 3'h4, 9'h110},
        {2'h1, 9'h021, 15'h0000, 3'h4, 9'h001},
        {2'h1, 9'h020, 15'h0000, 3'h0, 9'h001},
        {2'h2, 9'h000, 15'h0200, 3'h4, 9'h002},
        {2'h2, 9'h000, 15'h2F70, 3'h4, 9'h002},
        {2'h2, 9'h000, 15'h2F78, 3'h4, 9'h000},
        {2'h2, 9'h000, 15'h3E80, 3'h6, 9'h002},
        {2'h2, 9'h000, 15'h3E88, 3'h6, 9'h000},
        {2'h2, 9'h000, 15'h01F8, 3'h4, 9'h000},
        {2'h2, 9'h000, 15'h0201, 3'h4, 9'h000},
        {2'h2, 9'h000, 15'h0322, 3'h4, 9'h004},
        {2'h2, 9'h000, 15'h3202, 3'h6, 9'h004},
        {2'h2, 9'h000, 15'h2F7A, 3'h4, 9'h000},
        {2'h2, 9'h000, 15'h0326, 3'h4, 9'h008},
        {2'h2, 9'h000, 15'h0200, 3'h0, 9'h000},
        {2'h3, 9'h020, 15'h0200, 3'h4, 9'h003}
    };

    msc_stats dut (
        .clk_i         (clk_i),
        .reset_n_i     (reset_n_i),
        .reg_req_i     (req),
        .reg_rdata_o   (rdata),
        .reg_rvalid_o  (rvalid),
        .rx_enable_i   (cfg[2]),
        .long_frame_i  (cfg[1]),
        .full_duplex_i (cfg[0]),
        .tx_done_i     (tx_done),
        .tx_i          (tx),
        .rx_done_i     (rx_done),
        .rx_i          (rx)
    );

    msc_mac_engine_model eng (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .start_i   (start),
        .sel_i     (sel),
        .dly_i     (dly),
        .tx_val_i  (txv),
        .rx_val_i  (rxv),
        .busy_o    (busy),
        .tx_done_o (tx_done),
        .tx_o      (tx),
        .rx_done_o (rx_done),
        .rx_o      (rx)
    );

    ////////////////////////////////////////
    task automatic tick();
        @(posedge clk_i);
        #2;
    endtask : tick

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req.wr    = 1'b1;
        req.addr  = a;
        req.wdata = d;
        tick();
        req.wr = 1'b0;
        tick();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        req.rd   = 1'b1;
        req.addr = a;
        tick();
        req.rd = 1'b0;
        check({31'h0, rvalid}, 32'h1, "read valid missing");
        check(rdata, e, "read data");
        tick();
        check({31'h0, rvalid}, 32'h0, "read valid held too long");
    endtask : rd

    task automatic check_all(input logic [8:0] m, input logic [31:0] v);
        for (int j = 0; j < 9; j++)
            rd(msc_pkg::MULTI_COLLISION_COUNT_OFS + 8'(j) * msc_pkg::CNT_STRIDE, m[j] ? v : 32'h0);
    endtask : check_all

    // A read that clears in the very cycle of an increment must keep that increment.
    task automatic rd_beside_inc(input msc_tb_row_t r, input logic [7:0] a, input logic [31:0] pre);
        wr(a, pre);
        cfg   = r.cfg;
        sel   = r.sel;
        txv   = r.tx;
        rxv   = r.rx;
        dly   = 4'h0;
        start = 1'b1;
        tick();
        start    = 1'b0;
        req.rd   = 1'b1;
        req.addr = a;
        tick();
        req.rd = 1'b0;
        check(rdata, pre, "read beside increment");
        tick();
        rd(a, 32'h0000_0001);
    endtask : rd_beside_inc

    // The wait is bounded so that a model that never finishes cannot hang the run.
    task automatic send(input msc_tb_row_t r, input logic [3:0] d);
        cfg   = r.cfg;
        sel   = r.sel;
        txv   = r.tx;
        rxv   = r.rx;
        dly   = d;
        start = 1'b1;
        tick();
        start = 1'b0;
        for (int n = 0; n < 40 && busy; n++)
            tick();
        check({31'h0, busy}, 32'h0, "engine stuck");
    endtask : send

    task automatic end_sim();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            end_sim();
        end
    end

    initial begin
        reset_n_i = 1'b0;
        req = '0;
        cfg = 3'h4;
        start = 1'b0;
        sel = 2'h0;
        dly = 4'h0;
        txv = '0;
        rxv = '0;
        repeat (20) @(posedge clk_i);
        #2;
        reset_n_i = 1'b1;
        tick();
        check_all(9'h000, 32'h0);
        for (int i = 0; i < 28; i++) begin
            send(rows[i], i[3:0]);
            check_all(rows[i].exp, 32'h1);
        end
        wr(msc_pkg::TX_DEFERRED_COUNT_OFS, 32'h0000_1234);
        rd(msc_pkg::TX_DEFERRED_COUNT_OFS, 32'h0000_1234);
        rd(msc_pkg::TX_DEFERRED_COUNT_OFS, 32'h0000_0000);
        wr(msc_pkg::LATE_COLLISION_COUNT_OFS, 32'h0000_00FF);
        send(rows[5], 4'h0);
        rd(msc_pkg::LATE_COLLISION_COUNT_OFS, 32'h0000_00FF);
        wr(msc_pkg::RX_GOOD_FRAME_COUNT_OFS, 32'h00FF_FFFE);
        send(rows[15], 4'h2);
        send(rows[15], 4'h0);
        rd(msc_pkg::RX_GOOD_FRAME_COUNT_OFS, 32'h00FF_FFFF);
        wr(msc_pkg::MULTI_COLLISION_COUNT_OFS, 32'h0000_FFFF);
        send(rows[0], 4'h0);
        rd(msc_pkg::MULTI_COLLISION_COUNT_OFS, 32'h0000_FFFF);
        wr(msc_pkg::RX_CRC_ERROR_COUNT_OFS, 32'h0000_00FF);
        send(rows[22], 4'h0);
        rd(msc_pkg::RX_CRC_ERROR_COUNT_OFS, 32'h0000_00FF);
        rd_beside_inc(rows[5], msc_pkg::LATE_COLLISION_COUNT_OFS, 32'h0000_0003);
        rd_beside_inc(rows[9], msc_pkg::TX_UNDERRUN_COUNT_OFS, 32'h0000_0005);
        // A write and a read of one counter in the same cycle: the write wins.
        req.rd    = 1'b1;
        req.wr    = 1'b1;
        req.addr  = msc_pkg::EXCESS_COLLISION_COUNT_OFS;
        req.wdata = 32'h0000_0009;
        tick();
        req.rd = 1'b0;
        req.wr = 1'b0;
        tick();
        rd(msc_pkg::EXCESS_COLLISION_COUNT_OFS, 32'h0000_0009);
        wr(8'h6C, 32'h0000_0055);
        rd(8'h6C, 32'h0000_0000);
        rd(8'h44, 32'h0000_0000);
        check_all(9'h000, 32'h0);
        wr(msc_pkg::TX_UNDERRUN_COUNT_OFS, 32'h0000_0007);
        reset_n_i = 1'b0;
        tick();
        tick();
        reset_n_i = 1'b1;
        tick();
        rd(msc_pkg::TX_UNDERRUN_COUNT_OFS, 32'h0000_0000);
        end_sim();
    end
endmodule : tb_top
